// [service_request_status.sv]
// service request status byte and enable mask
// What this block does
// - code error always raises service request
// - enabled event sets its bit and bit 6
// - flags hold until poll, clear or reset
// - clear or controller reset disables optional conditions
// - automatic measurement never clears flags
// - code error weight always added in
// - enable sum is special function 22 suffix
// - status byte layout with zero bits
// - request flag also drives service line
module service_request_status (
  input wire logic clk_i, // 20 MHz clock
  input wire logic srst_i, // sync reset, power on
  input wire logic special_function_key_i, // keyboard entry pulse
  input wire logic [6:0] key_number_i, // keyboard function number
  input wire logic [2:0] key_suffix_i, // keyboard suffix
  input wire logic special_function_program_code_i, // bus entry pulse
  input wire logic [6:0] bus_number_i, // bus function number
  input wire logic [2:0] bus_suffix_i, // bus suffix
  input wire logic data_ready_i, // data ready event pulse
  input wire logic code_error_i, // bus code error pulse
  input wire logic instr_error_i, // instrument error pulse
  input wire logic auto_meas_i, // automatic operation active
  input wire logic serial_poll_i, // status byte read pulse
  input wire logic device_clear_i, // clear message executed
  input wire logic ctrl_reset_i, // controller reset or clear function
  output logic [7:0] status_byte_o, // status byte
  output logic srq_o, // service request line, high asserts
  output logic [2:0] enable_mask_o // current enable set
);
  import srq_pkg::*;

  srq_entry_if ent ();

  srq_entry_latch u_entry (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .key_valid_i(special_function_key_i),
    .key_number_i(key_number_i),
    .key_suffix_i(key_suffix_i),
    .bus_valid_i(special_function_program_code_i),
    .bus_number_i(bus_number_i),
    .bus_suffix_i(bus_suffix_i),
    .ent(ent)
  );

  logic [2:0] mask_r, mask_nxt;
  logic [2:0] cond_r, cond_nxt;
  logic rqs_r, rqs_nxt;
  logic [2:0] events;
  logic [2:0] hits;
  logic clr_all;

  // event vector in status bit order
  always_comb begin
    events = 3'h0;
    events[BIT_DATA_READY] = data_ready_i;
    events[BIT_CODE_ERROR] = code_error_i;
    events[BIT_INSTR_ERROR] = instr_error_i;
  end

  // poll, clear or controller reset clears flags; automatic run does not
  assign clr_all = serial_poll_i | device_clear_i | ctrl_reset_i;
  assign hits = events & mask_r;

  // enable mask next value
  always_comb begin
    mask_nxt = mask_r;
    if (device_clear_i || ctrl_reset_i) begin
      mask_nxt = MASK_RESET;
    end else if (ent.valid && ent.number == SF_SRQ_ENABLE) begin
      mask_nxt = ent.suffix | W_CODE_ERROR;
    end
  end

  // status flags next value; new event beats a same cycle clear
  always_comb begin
    cond_nxt = clr_all ? 3'h0 : cond_r;
    rqs_nxt = clr_all ? 1'b0 : rqs_r;
    if (|hits) begin
      cond_nxt = cond_nxt | hits;
      rqs_nxt = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_r <= MASK_RESET;
      cond_r <= 3'h0;
      rqs_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      cond_r <= cond_nxt;
      rqs_r <= rqs_nxt;
    end
  end

  // output flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_byte_o <= STATUS_RESET;
      srq_o <= 1'b0;
      enable_mask_o <= MASK_RESET;
    end else begin
      status_byte_o <= {1'b0, rqs_nxt, 3'b000, cond_nxt};
      srq_o <= rqs_nxt;
      enable_mask_o <= mask_nxt;
    end
  end

  a_code_err_srq: assert property (
    @(posedge clk_i) disable iff (srst_i)
    code_error_i |=> status_byte_o[BIT_CODE_ERROR] && srq_o)
    else $error("code error did not raise request");

  a_enabled_sets: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (|(events & mask_r)) |=> status_byte_o[BIT_RQS])
    else $error("enabled event did not set request bit");

  a_masked_quiet: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!status_byte_o[BIT_DATA_READY] && !data_ready_i && !clr_all)
      |=> !status_byte_o[BIT_DATA_READY])
    else $error("data ready bit set without event");

  a_flags_hold: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (srq_o && !clr_all) |=> srq_o)
    else $error("request dropped without clear");

  a_poll_clears: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (serial_poll_i && !(|hits)) |=> status_byte_o == 8'h00 && !srq_o)
    else $error("poll did not clear status");

  a_clear_mask: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (device_clear_i || ctrl_reset_i) |=> enable_mask_o == MASK_RESET)
    else $error("clear did not reset enable set");

  a_auto_keeps: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (auto_meas_i && srq_o && !clr_all) |=> $stable(srq_o))
    else $error("automatic run cleared request");

  a_code_always: assert property (
    @(posedge clk_i) disable iff (srst_i)
    enable_mask_o[BIT_CODE_ERROR])
    else $error("code error condition disabled");

  a_sf22_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (ent.valid && ent.number == SF_SRQ_ENABLE && !device_clear_i
      && !ctrl_reset_i)
      |=> enable_mask_o == ($past(ent.suffix) | W_CODE_ERROR))
    else $error("enable sum not loaded");

  a_zero_bits: assert property (
    @(posedge clk_i) disable iff (srst_i)
    status_byte_o[7] == 1'b0 && status_byte_o[5:3] == 3'b000
      && status_byte_o[BIT_RQS] == srq_o)
    else $error("status byte layout wrong");

  // flags against clears and unmasked events
  a_clr_quiet: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (clr_all && !(|hits)) |=> status_byte_o == STATUS_RESET && !srq_o)
    else $error("clear left a flag set");

  a_clr_keeps_hit: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (clr_all && (|hits)) |=> status_byte_o[2:0] == $past(hits) && srq_o)
    else $error("event lost to a same cycle clear");

  a_no_hit_hold: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!clr_all && !(|hits)) |=> status_byte_o == $past(status_byte_o))
    else $error("status changed without event or clear");

  a_instr_quiet: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!status_byte_o[BIT_INSTR_ERROR] && !hits[BIT_INSTR_ERROR])
      |=> !status_byte_o[BIT_INSTR_ERROR])
    else $error("instrument error bit set while masked");

  a_rqs_quiet: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!srq_o && !(|hits)) |=> !srq_o)
    else $error("service line raised without enabled event");

  a_ready_enabled: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (data_ready_i && mask_r[BIT_DATA_READY])
      |=> status_byte_o[BIT_DATA_READY] && srq_o)
    else $error("enabled data ready did not raise request");

  a_instr_enabled: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (instr_error_i && mask_r[BIT_INSTR_ERROR])
      |=> status_byte_o[BIT_INSTR_ERROR] && srq_o)
    else $error("enabled instrument error did not raise request");

  a_rqs_with_bit: assert property (
    @(posedge clk_i) disable iff (srst_i)
    srq_o |-> (|status_byte_o[2:0]))
    else $error("request set with no condition bit");

  a_bit_with_rqs: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (|status_byte_o[2:0]) |-> srq_o)
    else $error("condition bit set without request");

  a_auto_no_drop: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (auto_meas_i && !clr_all)
      |=> (status_byte_o & $past(status_byte_o)) == $past(status_byte_o))
    else $error("automatic run dropped a status bit");

  // enable set kept unless loaded or cleared
  a_mask_hold: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!device_clear_i && !ctrl_reset_i
      && !(ent.valid && ent.number == SF_SRQ_ENABLE))
      |=> enable_mask_o == $past(enable_mask_o))
    else $error("enable set changed without entry");

  // outputs held at power on values through reset
  a_reset_values: assert property (
    @(posedge clk_i)
    srst_i |=> status_byte_o == STATUS_RESET && !srq_o
      && enable_mask_o == MASK_RESET)
    else $error("reset values wrong");
endmodule : service_request_status

// [srq_entry_if.sv]
// special function entry carried between the two modules
interface srq_entry_if;
  logic valid;
  logic [6:0] number;
  logic [2:0] suffix;
  srq_pkg::entry_src_t src;
  modport src_side (output valid, output number, output suffix, output src);
  modport dst_side (input valid, input number, input suffix, input src);
endinterface : srq_entry_if

// [srq_entry_latch.sv]
// registers special function entries from keyboard or bus
module srq_entry_latch (
  input wire logic clk_i, // 20 MHz clock
  input wire logic srst_i, // sync reset
  input wire logic key_valid_i, // keyboard entry pulse
  input wire logic [6:0] key_number_i, // keyboard function number
  input wire logic [2:0] key_suffix_i, // keyboard suffix
  input wire logic bus_valid_i, // program code entry pulse
  input wire logic [6:0] bus_number_i, // program code number
  input wire logic [2:0] bus_suffix_i, // program code suffix
  srq_entry_if.src_side ent // registered entry
);
  import srq_pkg::*;
  logic valid_r, valid_nxt;
  logic [6:0] num_r, num_nxt;
  logic [2:0] suf_r, suf_nxt;
  entry_src_t src_r, src_nxt;

  // bus entry wins when both arrive together
  always_comb begin
    valid_nxt = key_valid_i | bus_valid_i;
    num_nxt = num_r;
    suf_nxt = suf_r;
    src_nxt = SRC_NONE;
    if (bus_valid_i) begin
      num_nxt = bus_number_i;
      suf_nxt = bus_suffix_i;
      src_nxt = SRC_BUS;
    end else if (key_valid_i) begin
      num_nxt = key_number_i;
      suf_nxt = key_suffix_i;
      src_nxt = SRC_KEY;
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      valid_r <= 1'b0;
      num_r <= 7'h00;
      suf_r <= 3'h0;
      src_r <= SRC_NONE;
    end else begin
      valid_r <= valid_nxt;
      num_r <= num_nxt;
      suf_r <= suf_nxt;
      src_r <= src_nxt;
    end
  end

  assign ent.valid = valid_r;
  assign ent.number = num_r;
  assign ent.suffix = suf_r;
  assign ent.src = src_r;

  // entry taken from the right source
  a_bus_wins: assert property (
    @(posedge clk_i) disable iff (srst_i)
    bus_valid_i |=> valid_r && src_r == SRC_BUS
      && num_r == $past(bus_number_i) && suf_r == $past(bus_suffix_i))
    else $error("program code entry not taken");

  a_key_taken: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (key_valid_i && !bus_valid_i) |=> valid_r && src_r == SRC_KEY
      && num_r == $past(key_number_i) && suf_r == $past(key_suffix_i))
    else $error("keyboard entry not taken");

  a_entry_idle: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!key_valid_i && !bus_valid_i) |=> !valid_r && src_r == SRC_NONE)
    else $error("entry valid without pulse");
endmodule : srq_entry_latch

// [srq_pkg.sv]
// shared constants for the service request status block
package srq_pkg;
  localparam int SF_NUM_W = 7;
  localparam logic [SF_NUM_W-1:0] SF_SRQ_ENABLE = 7'h16; // function 22
  localparam int MASK_W = 3;
  localparam logic [MASK_W-1:0] W_DATA_READY = 3'h1;
  localparam logic [MASK_W-1:0] W_CODE_ERROR = 3'h2;
  localparam logic [MASK_W-1:0] W_INSTR_ERROR = 3'h4;
  localparam logic [MASK_W-1:0] MASK_RESET = 3'h2; // code error only
  localparam int BIT_DATA_READY = 0;
  localparam int BIT_CODE_ERROR = 1;
  localparam int BIT_INSTR_ERROR = 2;
  localparam int BIT_RQS = 6; // weight 64
  localparam logic [7:0] STATUS_RESET = 8'h00;
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_KEY = 2'b01,
    SRC_BUS = 2'b10
  } entry_src_t;
endpackage : srq_pkg

// [srq_poll_ctrl.sv]
// bus controller model: serial polls and program codes
module srq_poll_ctrl (
  input wire logic clk_i, // bench clock
  output logic poll_o, // serial poll pulse
  output logic code_o, // program code pulse
  output logic [6:0] num_o, // function number
  output logic [2:0] sfx_o // enable sum suffix
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    poll_o = 1'b0;
    code_o = 1'b0;
    num_o = 7'h7f;
    sfx_o = 3'h7;
  end
  // one-cycle poll that reads and clears the flags
  task automatic poll();
    @(posedge clk_i) poll_o <= 1'b1;
    @(posedge clk_i) poll_o <= 1'b0;
  endtask : poll
  // code entry; released fields show the inverse value
  task automatic send(input logic [6:0] n, input logic [2:0] s);
    @(posedge clk_i) begin
      code_o <= 1'b1;
      num_o <= n;
      sfx_o <= s;
    end
    @(posedge clk_i) begin
      code_o <= 1'b0;
      num_o <= ~n;
      sfx_o <= ~s;
    end
  endtask : send
endmodule : srq_poll_ctrl

// [tb_service_request_status.sv]
// self-checking bench for the service request status block
module tb_service_request_status;
  timeunit 1ns;
  timeprecision 1ns;
  import srq_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic key_i = 1'b0;
  logic auto_i = 1'b0;
  logic [6:0] kn = 7'h00;
  logic [2:0] ks = 3'h0;
  logic [2:0] ev = 3'h0;
  logic [1:0] clr = 2'b00;
  logic poll, code, srq_o;
  logic [6:0] bn;
  logic [2:0] bs, enable_mask_o;
  logic [7:0] status_byte_o;
  int failures = 0;
  int checks = 0;
  // 50 ns clock
  always #25 clk_i = ~clk_i;
  srq_poll_ctrl i_ctrl (.clk_i(clk_i), .poll_o(poll), .code_o(code),
    .num_o(bn), .sfx_o(bs));
  service_request_status i_dut (.clk_i(clk_i), .srst_i(srst_i),
    .special_function_key_i(key_i), .key_number_i(kn),
    .key_suffix_i(ks), .special_function_program_code_i(code),
    .bus_number_i(bn), .bus_suffix_i(bs), .data_ready_i(ev[0]),
    .code_error_i(ev[1]), .instr_error_i(ev[2]), .auto_meas_i(auto_i),
    .serial_poll_i(poll), .device_clear_i(clr[0]),
    .ctrl_reset_i(clr[1]), .status_byte_o(status_byte_o),
    .srq_o(srq_o), .enable_mask_o(enable_mask_o));
  task automatic chk(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // compare all outputs once the edge has landed
  task automatic see_out(input logic [7:0] sb, input logic [2:0] m);
    #1;
    chk("status", status_byte_o, sb);
    chk("srq", {7'h00, srq_o}, {7'h00, sb[6]});
    chk("mask", {5'h00, enable_mask_o}, {5'h00, m});
  endtask : see_out
  // one-cycle event and clear pulses
  task automatic pulse(input logic [2:0] e, input logic [1:0] c);
    @(posedge clk_i) begin
      ev <= e;
      clr <= c;
    end
    @(posedge clk_i) begin
      ev <= 3'h0;
      clr <= 2'b00;
    end
  endtask : pulse
  // keyboard entry, waits out the two-edge answer
  task automatic key(input logic [6:0] n, input logic [2:0] s);
    @(posedge clk_i) begin
      key_i <= 1'b1;
      kn <= n;
      ks <= s;
    end
    @(posedge clk_i) key_i <= 1'b0;
    @(posedge clk_i);
  endtask : key
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #100us;
    failures++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    see_out(STATUS_RESET, MASK_RESET);
    pulse(W_CODE_ERROR, 2'b00);
    see_out(8'h42, MASK_RESET);
    @(posedge clk_i) auto_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    see_out(8'h42, MASK_RESET);
    i_ctrl.poll();
    see_out(8'h00, MASK_RESET);
    $display("test code error done");
    key(SF_SRQ_ENABLE, W_INSTR_ERROR);
    see_out(8'h00, 3'h6);
    key(7'h15, 3'h5);
    see_out(8'h00, 3'h6);
    i_ctrl.send(SF_SRQ_ENABLE, W_DATA_READY);
    @(posedge clk_i);
    see_out(8'h00, 3'h3);
    pulse(W_DATA_READY | W_INSTR_ERROR, 2'b00);
    see_out(8'h41, 3'h3);
    pulse(3'h0, 2'b01);
    see_out(8'h00, MASK_RESET);
    pulse(W_DATA_READY, 2'b00);
    see_out(8'h00, MASK_RESET);
    $display("test enable and device clear done");
    i_ctrl.send(SF_SRQ_ENABLE, 3'h5);
    @(posedge clk_i);
    see_out(8'h00, 3'h7);
    pulse(W_INSTR_ERROR, 2'b00);
    see_out(8'h44, 3'h7);
    pulse(3'h0, 2'b10);
    see_out(8'h00, MASK_RESET);
    $display("test controller reset done");
    fork
      key(SF_SRQ_ENABLE, W_DATA_READY);
      i_ctrl.send(SF_SRQ_ENABLE, W_INSTR_ERROR);
    join
    see_out(8'h00, 3'h6);
    pulse(W_CODE_ERROR, 2'b01);
    see_out(8'h42, MASK_RESET);
    fork
      i_ctrl.send(SF_SRQ_ENABLE, W_INSTR_ERROR);
      begin
        @(posedge clk_i);
        pulse(3'h0, 2'b01);
      end
    join
    see_out(8'h00, MASK_RESET);
    $display("test priorities done");
    i_ctrl.send(SF_SRQ_ENABLE, 3'h5);
    @(posedge clk_i);
    pulse(W_DATA_READY, 2'b00);
    see_out(8'h41, 3'h7);
    @(posedge clk_i) srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    see_out(STATUS_RESET, MASK_RESET);
    $display("test mid-run reset done");
    test_done();
  end
endmodule : tb_service_request_status
